// ### design/ptb_defs.svh
/*
 * offsets, field positions, reset values and divider taps of the periodic tick timebase.
 * assumes inclusion by bare name from the package and the timebase module.
 */
`ifndef PTB_DEFS_SVH
`define PTB_DEFS_SVH

`define PTB_AW 8
`define PTB_OFS_CTRL 8'h00
`define PTB_OFS_STS 8'h04
`define PTB_OFS_CLR 8'h08
`define PTB_OFS_IEN 8'h0c

`define PTB_B_BANK 0
`define PTB_B_TON 1
`define PTB_B_TIE 2
`define PTB_B_ACK 3
`define PTB_B_RATE_LO 4
`define PTB_B_RATE_HI 6
`define PTB_B_FLAG 7
`define PTB_RST_CTRL 8'h00

`define PTB_STS_W 2
`define PTB_S_TICK 0
`define PTB_S_DENY 1
`define PTB_RST_STS 2'h0

`define PTB_PRE_W 7
`define PTB_STG_W 15

// counter bit that rises at half the tap: log2(tap) - 1
`define PTB_TAP_0_0 5'h0e
`define PTB_TAP_0_1 5'h0c
`define PTB_TAP_0_2 5'h0a
`define PTB_TAP_0_3 5'h06
`define PTB_TAP_0_4 5'h05
`define PTB_TAP_0_5 5'h04
`define PTB_TAP_0_6 5'h03
`define PTB_TAP_0_7 5'h02
`define PTB_TAP_1_0 5'h15
`define PTB_TAP_1_1 5'h13
`define PTB_TAP_1_2 5'h11
`define PTB_TAP_1_3 5'h0d
`define PTB_TAP_1_4 5'h0c
`define PTB_TAP_1_5 5'h0b
`define PTB_TAP_1_6 5'h0a
`define PTB_TAP_1_7 5'h09

`endif

// ### design/ptb_pkg.sv
/*
 * types of the periodic tick timebase: apb carrier structs, control layout, bus states.
 * assumes ptb_defs.svh is on the include path.
 */
package ptb_pkg;
`include "ptb_defs.svh"

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [`PTB_AW-1:0] paddr;
		logic [31:0] pwdata;
	} ptb_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ptb_apb_rsp_t;

	typedef struct packed {
		logic flag;
		logic [2:0] rate;
		logic ack;
		logic tie;
		logic ton;
		logic bank;
	} ptb_ctrl_t;

	typedef enum logic [1:0] {
		PTB_ST_IDLE = 2'b01,
		PTB_ST_RESP = 2'b10
	} ptb_apb_st_t;
endpackage

// ### design/ptb_timebase.sv
/*
 * periodic tick timebase: divider chain, tick flag, apb register slave, interrupt block.
 * assumes one 100 MHz clock; the two tick source clocks arrive as asynchronous pins
 * and low-power mode levels come from logic on mclk_i.
 */
`timescale 1ns/1ps
`include "ptb_defs.svh"

module ptb_timebase #(
	parameter int PRE_W = `PTB_PRE_W,
	parameter int STG_W = `PTB_STG_W
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic ext_clk_i,
	input wire logic int_clk_i,
	input wire logic ext_clock_gen_on_i,
	input wire logic wait_mode_i,
	input wire logic stop_mode_i,
	input wire logic osc_run_in_stop_i,
	input wire ptb_pkg::ptb_apb_req_t apb_i,
	output ptb_pkg::ptb_apb_rsp_t apb_o,
	output logic tick_irq_o,
	output logic irq_o
);
	import ptb_pkg::*;

	localparam int CNT_W = PRE_W + STG_W;

	////////////////////////////////////////////////////////////////////////
	// decoding

	function automatic logic [3:0] reg_sel(input logic [`PTB_AW-1:0] a);
		logic [3:0] s;
		s = 4'h0;
		case (a)
			`PTB_OFS_CTRL: s = 4'h1;
			`PTB_OFS_STS: s = 4'h2;
			`PTB_OFS_CLR: s = 4'h4;
			`PTB_OFS_IEN: s = 4'h8;
			default: s = 4'h0;
		endcase
		return s;
	endfunction

	function automatic logic [4:0] tap_idx(input logic bank, input logic [2:0] rate);
		logic [4:0] t;
		t = 5'h00;
		case ({bank, rate})
			4'h0: t = `PTB_TAP_0_0;
			4'h1: t = `PTB_TAP_0_1;
			4'h2: t = `PTB_TAP_0_2;
			4'h3: t = `PTB_TAP_0_3;
			4'h4: t = `PTB_TAP_0_4;
			4'h5: t = `PTB_TAP_0_5;
			4'h6: t = `PTB_TAP_0_6;
			4'h7: t = `PTB_TAP_0_7;
			4'h8: t = `PTB_TAP_1_0;
			4'h9: t = `PTB_TAP_1_1;
			4'ha: t = `PTB_TAP_1_2;
			4'hb: t = `PTB_TAP_1_3;
			4'hc: t = `PTB_TAP_1_4;
			4'hd: t = `PTB_TAP_1_5;
			4'he: t = `PTB_TAP_1_6;
			4'hf: t = `PTB_TAP_1_7;
			default: t = 5'h00;
		endcase
		return t;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// declarations

	ptb_ctrl_t ctrl_q;
	ptb_apb_st_t st_q;
	logic [CNT_W-1:0] cnt_q;
	logic [`PTB_STS_W-1:0] sts_q;
	logic [`PTB_STS_W-1:0] ien_q;
	logic [1:0] ext_sync_q;
	logic [1:0] int_sync_q;
	logic ext_prev_q;
	logic int_prev_q;
	logic tap_prev_q;
	logic src_edge;
	logic run;
	logic tap_bit;
	logic tap_rise;
	logic lowpwr;
	logic req;
	logic xfer;
	logic [3:0] sel;
	logic wr_ctrl;
	logic ack_wr;
	logic deny;
	logic [31:0] rd_d;

	////////////////////////////////////////////////////////////////////////
	// tick source

	// both sources are synchronised all the time so a switch does not
	// see a stale edge from the other one
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ext_sync_q <= 2'h0;
			int_sync_q <= 2'h0;
			ext_prev_q <= 1'b0;
			int_prev_q <= 1'b0;
		end else begin
			ext_sync_q <= {ext_sync_q[0], ext_clk_i};
			int_sync_q <= {int_sync_q[0], int_clk_i};
			ext_prev_q <= ext_sync_q[1];
			int_prev_q <= int_sync_q[1];
		end
	end

	always_comb begin
		if (ext_clock_gen_on_i) begin
			src_edge = ext_sync_q[1] & ~ext_prev_q;
		end else begin
			src_edge = int_sync_q[1] & ~int_prev_q;
		end
	end

	// source must stay below a quarter of mclk for the edge detect
	assign run = ~(stop_mode_i & ~osc_run_in_stop_i);

	////////////////////////////////////////////////////////////////////////
	// divider chain

	// prescaler stages below the fifteen tap stages, one counter for both
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cnt_q <= '0;
		end else if (!ctrl_q.ton) begin
			cnt_q <= '0;
		end else if (run && src_edge) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	// rising tap bit: half a period after start, then every full tap
	assign tap_bit = cnt_q[tap_idx(ctrl_q.bank, ctrl_q.rate)];
	assign tap_rise = tap_bit & ~tap_prev_q;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			tap_prev_q <= 1'b0;
		end else begin
			tap_prev_q <= tap_bit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb slave

	assign lowpwr = wait_mode_i | stop_mode_i;
	assign req = apb_i.psel & apb_i.penable;
	assign xfer = req & (st_q == PTB_ST_RESP);
	assign sel = reg_sel(apb_i.paddr);
	assign deny = lowpwr | (sel == 4'h0);
	assign wr_ctrl = xfer & apb_i.pwrite & sel[0] & ~lowpwr;
	assign ack_wr = wr_ctrl & apb_i.pwdata[`PTB_B_ACK];

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			st_q <= PTB_ST_IDLE;
		end else begin
			case (st_q)
				PTB_ST_IDLE: begin
					if (req) begin
						st_q <= PTB_ST_RESP;
					end
				end
				PTB_ST_RESP: begin
					st_q <= PTB_ST_IDLE;
				end
				default: begin
					st_q <= PTB_ST_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		rd_d = 32'h0000_0000;
		if (!lowpwr) begin
			case (sel)
				4'h1: rd_d = {24'h00_0000, ctrl_q.flag, ctrl_q.rate, 1'b0,
					ctrl_q.tie, ctrl_q.ton, ctrl_q.bank};
				4'h2: rd_d = {{(32-`PTB_STS_W){1'b0}}, sts_q};
				4'h8: rd_d = {{(32-`PTB_STS_W){1'b0}}, ien_q};
				default: rd_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			apb_o <= '0;
		end else if (st_q == PTB_ST_IDLE && req) begin
			apb_o.pready <= 1'b1;
			apb_o.pslverr <= deny;
			apb_o.prdata <= apb_i.pwrite ? 32'h0000_0000 : rd_d;
		end else begin
			apb_o <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control register

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ctrl_q <= `PTB_RST_CTRL;
		end else begin
			if (wr_ctrl) begin
				ctrl_q.bank <= apb_i.pwdata[`PTB_B_BANK];
				ctrl_q.ton <= apb_i.pwdata[`PTB_B_TON];
				ctrl_q.tie <= apb_i.pwdata[`PTB_B_TIE];
				// rate is not guarded; software changes it only when disabled
				ctrl_q.rate <= apb_i.pwdata[`PTB_B_RATE_HI:`PTB_B_RATE_LO];
			end
			ctrl_q.ack <= 1'b0;
			// set wins over a simultaneous acknowledge
			if (tap_rise) begin
				ctrl_q.flag <= 1'b1;
			end else if (ack_wr) begin
				ctrl_q.flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			tick_irq_o <= 1'b0;
		end else begin
			tick_irq_o <= ctrl_q.flag & ctrl_q.tie;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt block

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			sts_q <= `PTB_RST_STS;
			ien_q <= `PTB_RST_STS;
		end else begin
			for (int i = 0; i < `PTB_STS_W; i++) begin
				if (xfer && apb_i.pwrite && sel[2] && !lowpwr && apb_i.pwdata[i]) begin
					sts_q[i] <= 1'b0;
				end
			end
			if (tap_rise) begin
				sts_q[`PTB_S_TICK] <= 1'b1;
			end
			if (st_q == PTB_ST_IDLE && req && deny) begin
				sts_q[`PTB_S_DENY] <= 1'b1;
			end
			if (xfer && apb_i.pwrite && sel[3] && !lowpwr) begin
				ien_q <= apb_i.pwdata[`PTB_STS_W-1:0];
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(sts_q & ien_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions

	property p_hold_zero;
		@(posedge mclk_i) disable iff (srst_i)
		!ctrl_q.ton |=> (cnt_q == '0);
	endproperty
	a_hold_zero: assert property (p_hold_zero) else $error("counter not zero while disabled");

	property p_flag_set;
		@(posedge mclk_i) disable iff (srst_i)
		tap_rise |=> ctrl_q.flag && sts_q[`PTB_S_TICK];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("tap rise did not set flag");

	property p_ack_clr;
		@(posedge mclk_i) disable iff (srst_i)
		ack_wr && !tap_rise |=> !ctrl_q.flag;
	endproperty
	a_ack_clr: assert property (p_ack_clr) else $error("acknowledge did not clear flag");

	property p_ack_rd;
		@(posedge mclk_i) disable iff (srst_i)
		(st_q == PTB_ST_IDLE) && req && !apb_i.pwrite && sel[0]
			|=> apb_o.pready && !apb_o.prdata[`PTB_B_ACK];
	endproperty
	a_ack_rd: assert property (p_ack_rd) else $error("acknowledge bit read as one");

	property p_irq;
		@(posedge mclk_i) disable iff (srst_i)
		1'b1 |=> tick_irq_o == $past(ctrl_q.flag && ctrl_q.tie);
	endproperty
	a_irq: assert property (p_irq) else $error("pending enabled tick gave no request");

	property p_keep_flag;
		@(posedge mclk_i) disable iff (srst_i)
		wr_ctrl && !apb_i.pwdata[`PTB_B_TON] && !ack_wr && ctrl_q.flag |=> ctrl_q.flag;
	endproperty
	a_keep_flag: assert property (p_keep_flag) else $error("disable cleared the flag");

	property p_ack_zero;
		@(posedge mclk_i) disable iff (srst_i)
		wr_ctrl && !apb_i.pwdata[`PTB_B_ACK] && ctrl_q.flag |=> ctrl_q.flag;
	endproperty
	a_ack_zero: assert property (p_ack_zero) else $error("zero acknowledge cleared the flag");

	property p_reset;
		@(posedge mclk_i) disable iff (1'b0)
		srst_i |=> !ctrl_q.flag && !ctrl_q.tie && !ctrl_q.ton && ctrl_q.rate == 3'h0 && cnt_q == '0;
	endproperty
	a_reset: assert property (p_reset) else $error("reset left state behind");

	property p_stop_halt;
		@(posedge mclk_i) disable iff (srst_i)
		stop_mode_i && !osc_run_in_stop_i |=> $stable(cnt_q);
	endproperty
	a_stop_halt: assert property (p_stop_halt) else $error("counter moved in halted stop");

	property p_wait_run;
		@(posedge mclk_i) disable iff (srst_i)
		wait_mode_i && !stop_mode_i && ctrl_q.ton && src_edge |=> cnt_q != $past(cnt_q);
	endproperty
	a_wait_run: assert property (p_wait_run) else $error("counter stalled in wait");

	property p_lp_deny;
		@(posedge mclk_i) disable iff (srst_i)
		(st_q == PTB_ST_IDLE) && req && lowpwr |=> apb_o.pready && apb_o.pslverr && !wr_ctrl;
	endproperty
	a_lp_deny: assert property (p_lp_deny) else $error("register reached in low power");

	property p_irq_blk;
		@(posedge mclk_i) disable iff (srst_i)
		|(sts_q & ien_q) |=> irq_o;
	endproperty
	a_irq_blk: assert property (p_irq_blk) else $error("enabled status gave no interrupt");

	c_flag: cover property (@(posedge mclk_i) disable iff (srst_i) tap_rise ##1 ctrl_q.flag);
	c_ack: cover property (@(posedge mclk_i) disable iff (srst_i) ctrl_q.flag ##1 ack_wr ##1 !ctrl_q.flag);
	c_irq: cover property (@(posedge mclk_i) disable iff (srst_i) $rose(tick_irq_o));
	c_deny: cover property (@(posedge mclk_i) disable iff (srst_i) $rose(sts_q[`PTB_S_DENY]));
	c_stop_run: cover property (@(posedge mclk_i) disable iff (srst_i) stop_mode_i && osc_run_in_stop_i && tap_rise);

endmodule // ptb_timebase

// ### tb/ptb_src_model.sv
/*
 * tick source clock model: one clock at an eighth of mclk_i while run_i is high.
 * assumes mclk_i is the bench clock; the clock stands low while not running.
 */
`timescale 1ns/1ps
module ptb_src_model (
	input wire logic mclk_i,
	input wire logic run_i,
	output logic clk_o
);
	logic [1:0] div_q;
	initial begin
		clk_o = 1'b0;
		div_q = 2'h0;
	end
	// a still source must not creep the counter
	always @(posedge mclk_i) begin
		if (run_i) begin
			div_q <= div_q + 2'h1;
			if (div_q == 2'h3) clk_o <= ~clk_o;
		end else begin
			div_q <= 2'h0;
			clk_o <= 1'b0;
		end
	end
endmodule // ptb_src_model

// ### tb/periodic_tick_timebase_tb.sv
/*
 * testbench of the periodic tick timebase: apb tasks and sequences of calls.
 * assumes the design package and ptb_defs.svh on the include path.
 */
`timescale 1ns/1ps
`include "ptb_defs.svh"
module periodic_tick_timebase_tb;
	import ptb_pkg::*;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic ext_on = 1'b0, wait_m = 1'b0, stop_m = 1'b0, osc_stop = 1'b0;
	logic ext_run = 1'b0, int_run = 1'b0;
	logic ext_clk, int_clk, tick_irq, irq, hit, prev;
	ptb_apb_req_t req = '0;
	ptb_apb_rsp_t rsp;
	logic [31:0] rdat;
	logic rerr;
	int errors = 0, total_checks = 0, cyc = 0, t0, t1, ten;
	logic [7:0] cfg [5] = '{8'h76, 8'h66, 8'h46, 8'h36, 8'h77};
	int taps [5] = '{8, 16, 64, 128, 1024};
	always #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) cyc <= cyc + 1;
	ptb_src_model ext_src (.mclk_i(mclk_i), .run_i(ext_run), .clk_o(ext_clk));
	ptb_src_model int_src (.mclk_i(mclk_i), .run_i(int_run), .clk_o(int_clk));
	ptb_timebase uut (.mclk_i(mclk_i), .srst_i(srst_i), .ext_clk_i(ext_clk), .int_clk_i(int_clk),
		.ext_clock_gen_on_i(ext_on), .wait_mode_i(wait_m), .stop_mode_i(stop_m),
		.osc_run_in_stop_i(osc_stop), .apb_i(req), .apb_o(rsp), .tick_irq_o(tick_irq), .irq_o(irq));
	////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge mclk_i);
		req.psel <= 1'b1;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge mclk_i);
		req.penable <= 1'b1;
		n = 0;
		@(posedge mclk_i);
		while (rsp.pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				errors++;
				print_verdict();
			end
			@(posedge mclk_i);
		end
		rdat = rsp.prdata;
		rerr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		chk(rdat, e);
	endtask
	// rising edge only: a flag still high from before must fall first
	task automatic rise(input int lim);
		hit = 1'b0;
		prev = 1'b1;
		for (int i = 0; i < lim && !hit; i++) begin
			@(posedge mclk_i);
			if (tick_irq === 1'b1 && prev === 1'b0) begin
				hit = 1'b1;
				t1 = cyc;
			end
			prev = tick_irq;
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge mclk_i);
		srst_i <= 1'b0;
		int_run <= 1'b1;
		rd(`PTB_OFS_CTRL, 32'h0);
		rd(`PTB_OFS_STS, 32'h0);
		rd(`PTB_OFS_IEN, 32'h0);
		$display("test reset done");
		for (int k = 0; k < 5; k++) begin
			wr(`PTB_OFS_CTRL, {24'h0, cfg[k]});
			ten = cyc;
			rise(taps[k] * 8);
			t0 = t1;
			chk(hit && t0 - ten >= taps[k] * 4 - 8 && t0 - ten <= taps[k] * 4 + 12, 1);
			rd(`PTB_OFS_CTRL, {24'h0, cfg[k] | 8'h80});
			wr(`PTB_OFS_CTRL, {24'h0, cfg[k] | 8'h08});
			rd(`PTB_OFS_CTRL, {24'h0, cfg[k]});
			rise(taps[k] * 10);
			chk(t1 - t0, taps[k] * 8);
			wr(`PTB_OFS_CTRL, 32'h0);
			rd(`PTB_OFS_CTRL, 32'h80);
			wr(`PTB_OFS_CTRL, 32'h08);
			rd(`PTB_OFS_CTRL, 32'h0);
		end
		$display("test rates done");
		ext_on <= 1'b1;
		wr(`PTB_OFS_CTRL, 32'h76);
		rise(200);
		chk(hit, 0);
		ext_run <= 1'b1;
		rise(200);
		chk(hit, 1);
		ext_on <= 1'b0;
		wr(`PTB_OFS_CTRL, 32'h7e);
		wait_m <= 1'b1;
		xfer(`PTB_OFS_CTRL, 1'b0, 32'h0);
		chk(rerr, 1);
		chk(rdat, 32'h0);
		rise(200);
		chk(hit, 1);
		wait_m <= 1'b0;
		wr(`PTB_OFS_CTRL, 32'h7e);
		stop_m <= 1'b1;
		rise(300);
		chk(hit, 0);
		osc_stop <= 1'b1;
		rise(300);
		chk(hit, 1);
		stop_m <= 1'b0;
		$display("test clocks and modes done");
		wr(`PTB_OFS_CTRL, 32'h70);
		rd(`PTB_OFS_CTRL, 32'hf0);
		chk(tick_irq, 0);
		rd(`PTB_OFS_STS, 32'h3);
		wr(`PTB_OFS_IEN, 32'h1);
		rd(`PTB_OFS_IEN, 32'h1);
		chk(irq, 1);
		wr(`PTB_OFS_CLR, 32'h1);
		rd(`PTB_OFS_STS, 32'h2);
		chk(irq, 0);
		xfer(8'h10, 1'b0, 32'h0);
		chk(rerr, 1);
		$display("test interrupt block done");
		print_verdict();
	end
endmodule // periodic_tick_timebase_tb
